// ### rtl/dcss_regs.svh
/*
 * Constants of the daisy-chain serial slave frame block.
 * Assumes inclusion by bare name from the rtl/ folder.
 */
`ifndef DCSS_REGS_SVH
`define DCSS_REGS_SVH

// ****************************************************************
// Frame geometry, queue depth and fixed words
// ****************************************************************
`define DCSS_FRAME_BITS   16
`define DCSS_STEP_BITS    8
`define DCSS_CNT_W        8
`define DCSS_CMD_W        2
`define DCSS_ADDR_W       4
`define DCSS_ADDR_LSB     10
`define DCSS_DATA_W       10
`define DCSS_FIFO_DEPTH   8
`define DCSS_RST_WORD     16'h0000
`define DCSS_ERR_WORD     16'h8000

`endif

// ### rtl/dcss_pkg.sv
/*
 * Types shared by the serial slave frame block.
 * Assumes dcss_regs.svh is on the include path.
 */
package dcss_pkg;
   typedef enum logic [1:0] {
      DCSS_IDLE,
      DCSS_SHIFT,
      DCSS_CLOSE
   } dcss_state_e;
endpackage

// ### rtl/dcss_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronised active-low reset.
 */
`timescale 1ns/1ns
module dcss_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst_sync_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   wire              push;
   wire              pop;

   // Handshake decode
   assign in_ready  = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_ff[rd_ptr_ff];

   // Storage array
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ### rtl/dcss_slave.sv
/*
 * Serial slave frame engine: 16-bit frames, daisy chain lengths,
 * frame error flag, write words queued to the device core.
 * Assumes serial pins are asynchronous and sampled by core_clk,
 * which runs at least four times the serial clock rate.
 */
// Functional notes
// - Execute only 16 plus n times 8 clocks
// - Bad count sets error, discards command
// - Select release writes shift register out
// - Sample input on serial clock fall
// - Advance output on serial clock rise
// - Input frames arrive most significant first
// - Output sent most significant bit first
// - Output high impedance until select low
// - Frame is control bits then data
// - One shift register, in and out
// - Sixteen clocks form own frame; rest passes
// - Ignore lines while select high
// - Select fall loads pending response
// - First output bit is error OR input
// - Reply comes in the next transfer
`timescale 1ns/1ns
`include "dcss_regs.svh"
module dcss_slave
   import dcss_pkg::*;
#(
   parameter int FRAME_BITS = `DCSS_FRAME_BITS,
   parameter int FIFO_DEPTH = `DCSS_FIFO_DEPTH
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   input  wire logic                      select_low_pin,
   input  wire logic                      sclk_pin,
   input  wire logic                      sdi_pin,
   output logic                           sdo_out,
   output logic                           sdo_oe,
   input  wire logic [FRAME_BITS-1:0]     reply_word,
   output logic                           reply_taken,
   output logic [FRAME_BITS-1:0]          wr_word,
   output logic                           wr_valid,
   input  wire logic                      wr_ready,
   output logic                           frame_error_flag,
   output logic                           frame_busy
);
   // ****************************************************************
   // Reset release and pin synchronisers
   // ****************************************************************
   logic       rst_meta_ff;
   logic       rst_sync_b;
   logic [1:0] cs_sync_ff;
   logic [1:0] ck_sync_ff;
   logic [1:0] di_sync_ff;
   logic       cs_d_ff;
   logic       ck_d_ff;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_sync_b  <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_b  <= rst_meta_ff;
      end
   end

   // Two-flop synchronisers; select idles high
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cs_sync_ff <= 2'h3;
         ck_sync_ff <= 2'h0;
         di_sync_ff <= 2'h0;
         cs_d_ff    <= 1'b1;
         ck_d_ff    <= 1'b0;
      end else begin
         cs_sync_ff <= {cs_sync_ff[0], select_low_pin};
         ck_sync_ff <= {ck_sync_ff[0], sclk_pin};
         di_sync_ff <= {di_sync_ff[0], sdi_pin};
         cs_d_ff    <= cs_sync_ff[1];
         ck_d_ff    <= ck_sync_ff[1];
      end
   end

   // ****************************************************************
   // Edge decode
   // ****************************************************************
   wire cs_s      = cs_sync_ff[1];
   wire di_s      = di_sync_ff[1];
   wire cs_fall   = cs_d_ff & ~cs_s;
   wire cs_rise   = ~cs_d_ff & cs_s;
   // Serial edges count only while selected
   wire ck_fall   = ~cs_s & ~cs_d_ff & ck_d_ff & ~ck_sync_ff[1];
   wire ck_rise   = ~cs_s & ~cs_d_ff & ~ck_d_ff & ck_sync_ff[1];

   // ****************************************************************
   // Frame state
   // ****************************************************************
   dcss_state_e               state_ff;
   dcss_state_e               nxt_state;
   logic [FRAME_BITS-1:0]     shreg_ff;
   logic [`DCSS_CNT_W-1:0]    cnt_ff;
   logic                      odd_ff;
   logic                      past16_ff;
   logic                      sdo_ff;
   logic                      err_ff;
   logic                      wr_pend_ff;
   logic [FRAME_BITS-1:0]     wr_hold_ff;
   logic                      fifo_ready;

   // Count legality: 16 reached and a whole multiple of 8 after
   localparam int STEP_LSBS = $clog2(`DCSS_STEP_BITS);
   wire [STEP_LSBS-1:0] step_mod = cnt_ff[STEP_LSBS-1:0];
   wire count_ok  = past16_ff & (step_mod == '0) & ~odd_ff;
   // Bit leaving the register is the chain output
   wire shift_out = shreg_ff[FRAME_BITS-1];

   // Next frame state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         DCSS_IDLE: begin
            if (cs_fall) begin
               nxt_state = DCSS_SHIFT;
            end
         end
         DCSS_SHIFT: begin
            if (cs_rise) begin
               nxt_state = DCSS_CLOSE;
            end
         end
         DCSS_CLOSE: begin
            nxt_state = DCSS_IDLE;
         end
         default: begin
            nxt_state = DCSS_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_ff <= DCSS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Clock pulse counter
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cnt_ff    <= '0;
         past16_ff <= 1'b0;
         odd_ff    <= 1'b0;
      end else if (cs_fall) begin
         cnt_ff    <= '0;
         past16_ff <= 1'b0;
         odd_ff    <= 1'b0;
      end else if (ck_fall) begin
         cnt_ff <= cnt_ff + 1'b1;
         if (cnt_ff == `DCSS_CNT_W'(FRAME_BITS - 1)) begin
            past16_ff <= 1'b1;
         end
         if (cnt_ff == '1) begin
            odd_ff <= 1'b1;  // Overflow counts as illegal
         end
      end
   end

   // Shift register: load, sample, and output stage
   // Single shared shift register
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         shreg_ff <= `DCSS_RST_WORD;
         sdo_ff   <= 1'b0;
      end else if (cs_fall) begin
         shreg_ff <= reply_word;
         // First bit is error OR input
         sdo_ff   <= err_ff | di_s;
      end else if (ck_fall) begin
         shreg_ff <= {shreg_ff[FRAME_BITS-2:0], di_s};
      end else if (ck_rise) begin
         sdo_ff <= shift_out;
      end
   end

   // Error flag and write capture at select release
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         err_ff     <= 1'b0;
         wr_pend_ff <= 1'b0;
         wr_hold_ff <= '0;
      end else begin
         // Pending word leaves once the queue takes it; never twice
         if (wr_pend_ff & fifo_ready) begin
            wr_pend_ff <= 1'b0;
         end
         if (state_ff == DCSS_CLOSE) begin
            err_ff <= ~count_ok;
            if (count_ok) begin
               // Control and data bits as one word
               wr_pend_ff <= 1'b1;
               wr_hold_ff <= shreg_ff;
            end
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Drive output only while selected
   assign sdo_oe           = (state_ff == DCSS_SHIFT) & ~cs_s;
   assign sdo_out          = sdo_ff;
   // Reply word consumed at the next frame start
   assign reply_taken      = cs_fall;
   assign frame_error_flag = err_ff;
   assign frame_busy       = (state_ff != DCSS_IDLE);

   // Queue of accepted words toward the device core
   dcss_fifo #(
      .WIDTH (FRAME_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk   (core_clk),
      .rst_sync_b (rst_sync_b),
      .in_data    (wr_hold_ff),
      .in_valid   (wr_pend_ff),
      .in_ready   (fifo_ready),
      .out_data   (wr_word),
      .out_valid  (wr_valid),
      .out_ready  (wr_ready)
   );
endmodule

// ### verif/dcss_slave_props.sv
/* Concurrent checks on the serial slave frame ports.
   Assumes it is bound onto every dcss_slave instance. */
`timescale 1ns/1ns
module dcss_slave_props
   import dcss_pkg::*;
#(
   parameter int FRAME_BITS = 16
) (
   input wire logic                  core_clk,
   input wire logic                  rst_b,
   input wire logic                  select_low_pin,
   input wire logic                  sclk_pin,
   input wire logic                  sdi_pin,
   input wire logic                  sdo_out,
   input wire logic                  sdo_oe,
   input wire logic [FRAME_BITS-1:0] reply_word,
   input wire logic                  reply_taken,
   input wire logic [FRAME_BITS-1:0] wr_word,
   input wire logic                  wr_valid,
   input wire logic                  wr_ready,
   input wire logic                  frame_error_flag,
   input wire logic                  frame_busy
);
   // ***********************************************************
   // Port relations
   // ***********************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   oe_idle_a: assert property (select_low_pin [*8] |-> !sdo_oe)
      else $error("output driven while deselected");
   oe_on_a: assert property ($fell(select_low_pin) |-> ##[2:6] sdo_oe)
      else $error("output not enabled after select fall");
   oe_busy_a: assert property
      (sdo_oe |-> frame_busy && !$past(select_low_pin, 2))
      else $error("output driven outside a frame");
   take_at_fall_a: assert property
      ($fell(select_low_pin) |-> ##[1:5] reply_taken)
      else $error("reply not taken at select fall");
   take_once_a: assert property (reply_taken |=> !reply_taken)
      else $error("reply taken longer than one cycle");
   word_at_close_a: assert property ($rose(wr_valid) |-> select_low_pin)
      else $error("word queued while selected");
   err_at_close_a: assert property
      ($changed(frame_error_flag) |-> select_low_pin)
      else $error("error flag moved inside a frame");
   word_hold_a: assert property
      (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
      else $error("queued word lost while stalled");
   cover property ($rose(frame_error_flag));
   cover property ($rose(wr_valid));
   cover property (wr_valid && !wr_ready);
endmodule
bind dcss_slave dcss_slave_props #(.FRAME_BITS(FRAME_BITS)) u_props (
   .core_clk(core_clk), .rst_b(rst_b), .select_low_pin(select_low_pin),
   .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .sdo_out(sdo_out),
   .sdo_oe(sdo_oe), .reply_word(reply_word), .reply_taken(reply_taken),
   .wr_word(wr_word), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .frame_error_flag(frame_error_flag), .frame_busy(frame_busy));

// ### verif/dcss_host_model.sv
/* Host master model: select, serial clock and data in.
   Assumes the slave samples these lines with its own clock. */
`timescale 1ns/1ns
module dcss_host_model (
   output logic      select_low_pin,
   output logic      sclk_pin,
   output logic      sdi_pin,
   input  wire logic sdo_line
);
   // Idle levels at time zero
   initial begin
      select_low_pin = 1'b1;
      sclk_pin = 1'b0;
      sdi_pin = 1'b0;
   end
   task automatic send(input logic [31:0] v, input int n,
                       output logic first, output logic [31:0] so);
      so = '0;
      sdi_pin = v[n-1];
      #100 select_low_pin = 1'b0;
      #300 first = sdo_line;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_pin = v[i];
         #100 sclk_pin = 1'b1;
         // Output bit taken just before the falling edge
         #200 so = {so[30:0], sdo_line};
         sclk_pin = 1'b0;
         #100;
      end
      #300 select_low_pin = 1'b1;
      sdi_pin = ~sdi_pin; // Released line drifts
      #400;
   endtask
   // Clock pulses while the device is deselected
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         #200 sclk_pin = 1'b1;
         #200 sclk_pin = 1'b0;
         sdi_pin = ~sdi_pin;
      end
   endtask
endmodule

// ### verif/tb_top.sv
/* Self-checking bench for the serial slave frame block.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic        core_clk, rst_b, wr_ready, sdo_out, sdo_oe, sdo_last;
   logic        sel_b, sclk, sdi, sdo_line, first, reply_taken;
   logic        wr_valid, frame_error_flag, frame_busy;
   logic [15:0] reply_word, wr_word;
   logic [31:0] so_bits;
   logic [15:0] got_q[$];
   int          n_errors = 0;
   int          check_count = 0;
   // Clock and released output line
   initial begin
      core_clk = 1'b0;
      sdo_last = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (sdo_oe) sdo_last <= sdo_out;
   assign sdo_line = sdo_oe ? sdo_out : ~sdo_last;
   always @(posedge core_clk)
      if (wr_valid && wr_ready) got_q.push_back(wr_word);
   dcss_host_model host (.select_low_pin(sel_b), .sclk_pin(sclk),
      .sdi_pin(sdi), .sdo_line(sdo_line));
   dcss_slave #(.FRAME_BITS(16), .FIFO_DEPTH(8)) uut (
      .core_clk(core_clk), .rst_b(rst_b), .select_low_pin(sel_b),
      .sclk_pin(sclk), .sdi_pin(sdi), .sdo_out(sdo_out),
      .sdo_oe(sdo_oe), .reply_word(reply_word),
      .reply_taken(reply_taken), .wr_word(wr_word),
      .wr_valid(wr_valid), .wr_ready(wr_ready),
      .frame_error_flag(frame_error_flag), .frame_busy(frame_busy));
   // ***********************************************************
   // Tasks
   // ***********************************************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic frame(input logic [31:0] v, input int n);
      @(posedge core_clk);
      #3 host.send(v, n, first, so_bits);
      repeat (10) @(posedge core_clk);
   endtask
   task automatic test_lengths();
      int          lens[8] = '{16, 8, 24, 15, 32, 17, 23, 25};
      logic [31:0] v;
      logic        good;
      logic [63:0] s;
      foreach (lens[i]) begin
         v = 32'hc35a69a5 + i;
         got_q.delete();
         frame(v, lens[i]);
         good = (lens[i] >= 16) && (lens[i] % 8 == 0);
         `CHK("words", good ? 1 : 0, got_q.size())
         if (good) `CHK("word", v[15:0], got_q[0])
         // Reply word first, then the bits passed along the chain
         s = (64'(reply_word) << lens[i])
             | (64'(v) & ((64'h1 << lens[i]) - 64'h1));
         `CHK("reply_bits", s[47:16], so_bits)
         `CHK("err", !good, frame_error_flag)
      end
      $display("lengths done");
   endtask
   task automatic test_first_bit();
      frame(32'h000000ff, 17);
      frame(32'h00001234, 16);
      `CHK("first_err", 1'b1, first)
      frame(32'h00001234, 16);
      `CHK("first_ok", 1'b0, first)
      frame(32'h00008234, 16);
      `CHK("first_in", 1'b1, first)
      $display("first bit done");
   endtask
   task automatic test_deselect();
      got_q.delete();
      #3 host.idle_clocks(20);
      repeat (10) @(posedge core_clk);
      `CHK("idle_words", 0, got_q.size())
      `CHK("idle_oe", 1'b0, sdo_oe)
      frame(32'h00005aa5, 16);
      `CHK("after_idle", 16'h5aa5, got_q[0])
      $display("deselect done");
   endtask
   task automatic test_fifo();
      got_q.delete();
      #3 wr_ready = 1'b0;
      for (int i = 0; i < 8; i++) frame(32'h0000a000 + i, 16);
      `CHK("stalled", 0, got_q.size())
      @(posedge core_clk);
      #3 wr_ready = 1'b1;
      repeat (12) @(posedge core_clk);
      `CHK("drained", 8, got_q.size())
      for (int i = 0; i < 8; i++)
         `CHK("fifo_word", 16'ha000 + i, got_q[i])
      `CHK("empty", 1'b0, wr_valid)
      $display("fifo done");
   endtask
   // ***********************************************************
   // Main sequence and watchdog
   // ***********************************************************
   initial begin
      rst_b = 1'b0;
      wr_ready = 1'b1;
      reply_word = 16'h8001;
      repeat (4) @(posedge core_clk);
      #3 rst_b = 1'b1;
      repeat (6) @(posedge core_clk);
      `CHK("rst_oe", 1'b0, sdo_oe)
      `CHK("rst_err", 1'b0, frame_error_flag)
      test_lengths();
      test_first_bit();
      test_deselect();
      test_fifo();
      finish_test();
   end
   initial begin
      #2000000;
      n_errors++;
      finish_test();
   end
endmodule
